// File: abu_breakpoint.v
`include "abu_defs.vh"
`default_nettype none
module abu_breakpoint (
  // Clock, reset and enable
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // CPU core side
  input wire [15:0] cpu_addr,
  input wire cpu_addr_valid,
  input wire cpu_instr_last,
  input wire cpu_rti_exec,
  input wire cpu_in_wait,
  input wire cpu_in_stop,
  input wire monitor_mode,
  output wire break_request,
  output wire [15:0] break_vector,
  output reg break_in_progress,
  output wire wake_request,
  // Peripheral gating
  output wire timer_freeze,
  output wire watchdog_inhibit,
  output wire status_clear_allow
);

  reg break_enable_reg;
  reg break_active_flag_reg;
  reg [7:0] addr_high_reg;
  reg [7:0] addr_low_reg;
  reg break_wait_flag_reg;
  reg break_clear_flag_enable_reg;
  reg break_disable_watchdog_reg;
  reg pending_reg;
  // Read data is captured once per read transfer; this flag says the capture has happened.
  reg rd_valid_reg;
  reg [31:0] read_next;
  wire [15:0] bit_equal;

  // A write lands only on the edge that completes the access phase.
  wire wr = psel & penable & pwrite & clk_en;
  wire rd_sel = psel & ~pwrite;
  wire hit_ctrl = (paddr == `ABU_OFF_CTRL);
  wire hit_addrh = (paddr == `ABU_OFF_ADDRH);
  wire hit_addrl = (paddr == `ABU_OFF_ADDRL);
  wire hit_wake = (paddr == `ABU_OFF_WAKE);
  wire hit_flagclr = (paddr == `ABU_OFF_FLAGCLR);
  wire hit_aux = (paddr == `ABU_OFF_AUX);
  wire addr_ok = hit_ctrl | hit_addrh | hit_addrl | hit_wake | hit_flagclr | hit_aux;
  wire wr_ctrl = wr & hit_ctrl;
  wire wr_addrh = wr & hit_addrh;
  wire wr_addrl = wr & hit_addrl;
  wire wr_wake = wr & hit_wake;
  wire wr_flagclr = wr & hit_flagclr;
  wire wr_aux = wr & hit_aux;
  // Writing 1 to the wait flag has no effect; only a 0 clears it.
  wire wake_clear = wr_wake & ~pwdata[`ABU_BIT_WAIT];
  wire [15:0] break_address = {addr_high_reg, addr_low_reg};

  // One equality cell per address bit keeps the compare path flat and easy to time.
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_cmp
      assign bit_equal[gi] = ~(cpu_addr[gi] ^ break_address[gi]);
    end
  endgenerate

  // Match is only against CPU-generated program addresses.
  wire addr_match = break_enable_reg & cpu_addr_valid & (&bit_equal);
  wire sw_trigger = wr_ctrl & pwdata[`ABU_BIT_ACTIVE];
  wire trigger = addr_match | sw_trigger;

  // A low clock enable stalls the bus, so no write is dropped while state is frozen.
  // A read waits until its data has been captured; with the enable high that costs nothing.
  assign pready = clk_en & (pwrite | rd_valid_reg);
  // Unmapped addresses answer with an error.
  assign pslverr = psel & penable & ~addr_ok;

  // Request is held until the instruction boundary.
  assign break_request = (pending_reg | trigger) & cpu_instr_last &
                         ~break_in_progress;
  assign break_vector = monitor_mode ? `ABU_VEC_MON : `ABU_VEC_USER;
  assign wake_request = (pending_reg | trigger) & (cpu_in_stop | cpu_in_wait);
  assign timer_freeze = break_in_progress;
  assign watchdog_inhibit = break_in_progress & break_disable_watchdog_reg;
  // Outside a break status clears are always permitted.
  assign status_clear_allow = ~break_in_progress | break_clear_flag_enable_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_enable_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        break_enable_reg <= pwdata[`ABU_BIT_ENABLE];
      end
    end
  end

  // A hardware match wins over a clearing write in the same cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_active_flag_reg <= 1'b0;
    end else if (clk_en) begin
      if (trigger) begin
        break_active_flag_reg <= 1'b1;
      end else if (wr_ctrl) begin
        break_active_flag_reg <= 1'b0;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_high_reg <= `ABU_RST_BYTE;
    end else if (clk_en) begin
      if (wr_addrh) begin
        addr_high_reg <= pwdata[7:0];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_low_reg <= `ABU_RST_BYTE;
    end else if (clk_en) begin
      if (wr_addrl) begin
        addr_low_reg <= pwdata[7:0];
      end
    end
  end

  // A wake-up in the same cycle as a clearing write leaves the flag set, so no wake is lost.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_wait_flag_reg <= 1'b0;
    end else if (clk_en) begin
      if (wake_request) begin
        break_wait_flag_reg <= 1'b1;
      end else if (wake_clear) begin
        break_wait_flag_reg <= 1'b0;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_clear_flag_enable_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_flagclr) begin
        break_clear_flag_enable_reg <= pwdata[`ABU_BIT_CLRFE];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_disable_watchdog_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_aux) begin
        break_disable_watchdog_reg <= pwdata[`ABU_BIT_BDWD];
      end
    end
  end

  // A trigger that misses the instruction boundary waits here for the next one.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_reg <= 1'b0;
    end else if (clk_en) begin
      if (break_request) begin
        pending_reg <= 1'b0;
      end else if (trigger && !break_in_progress) begin
        pending_reg <= 1'b1;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_in_progress <= 1'b0;
    end else if (clk_en) begin
      if (break_request) begin
        break_in_progress <= 1'b1;
      end else if (cpu_rti_exec) begin
        break_in_progress <= 1'b0;
      end
    end
  end

  // The flag drops on the completing edge, so a back-to-back read captures afresh.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_valid_reg <= 1'b0;
    end else if (clk_en) begin
      if (psel && penable && pready) begin
        rd_valid_reg <= 1'b0;
      end else if (rd_sel && !rd_valid_reg) begin
        rd_valid_reg <= 1'b1;
      end
    end
  end

  always @* begin
    read_next = 32'h00000000;
    if (hit_ctrl) begin
      read_next = {24'h000000, break_enable_reg, break_active_flag_reg, 6'h00};
    end else if (hit_addrh) begin
      read_next = {24'h000000, addr_high_reg};
    end else if (hit_addrl) begin
      read_next = {24'h000000, addr_low_reg};
    end else if (hit_wake) begin
      read_next = {30'h00000000, break_wait_flag_reg, 1'b0};
    end else if (hit_flagclr) begin
      read_next = {24'h000000, break_clear_flag_enable_reg, 7'h00};
    end else if (hit_aux) begin
      read_next = {31'h00000000, break_disable_watchdog_reg};
    end else begin
      read_next = 32'h00000000;
    end
  end

  // Read data is taken once per transfer and then stands until the next read.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (clk_en) begin
      if (rd_sel && !rd_valid_reg) begin
        prdata <= read_next;
      end
    end
  end

endmodule // abu_breakpoint
`default_nettype wire

// File: abu_chk.sv
`default_nettype none
module abu_chk (
  input wire logic pclk, presetn, monitor_mode, cpu_instr_last, cpu_rti_exec, cpu_in_wait,
  input wire logic cpu_in_stop, break_request, break_in_progress, wake_request,
  input wire logic timer_freeze, watchdog_inhibit, status_clear_allow,
  input wire logic [15:0] break_vector
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  vector_sel_a: assert property (break_vector == (monitor_mode ? 16'hFEFC : 16'hFFFC))
    else $error("vector");
  req_last_a: assert property (break_request |-> cpu_instr_last && !break_in_progress)
    else $error("request");
  entry_seq_a: assert property (break_request |=> break_in_progress)
    else $error("entry");
  rti_exit_a: assert property (break_in_progress && cpu_rti_exec |=> !break_in_progress)
    else $error("exit");
  timer_frz_a: assert property (timer_freeze == break_in_progress)
    else $error("freeze");
  wdog_gate_a: assert property (watchdog_inhibit |-> break_in_progress)
    else $error("watchdog");
  clear_free_a: assert property (!break_in_progress |-> status_clear_allow)
    else $error("clear");
  wake_src_a: assert property (wake_request |-> cpu_in_wait || cpu_in_stop)
    else $error("wake");
  cover property (break_request && monitor_mode);
  cover property ($fell(break_in_progress));
  cover property (wake_request);
endmodule // abu_chk
bind abu_breakpoint abu_chk i_chk (.*);
`default_nettype wire

// File: abu_cpu_model.sv
`default_nettype none
module abu_cpu_model (
  input wire logic pclk, presetn, waiting, break_in_progress,
  input wire logic [3:0] rti_delay,
  output logic cpu_instr_last, cpu_rti_exec, cpu_addr_valid, cpu_in_wait,
  output logic [15:0] cpu_addr
);
  logic [15:0] pc_reg;
  logic [3:0] cnt_reg;
  // No fetch in wait or break, so the bus shows the inverted address and cannot match by accident.
  assign cpu_addr_valid = !waiting && !break_in_progress;
  assign cpu_in_wait = waiting;
  assign cpu_addr = cpu_addr_valid ? pc_reg : ~pc_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pc_reg, cnt_reg, cpu_instr_last, cpu_rti_exec} <= {16'h1200, 4'h0, 2'b00};
    end else begin
      cpu_instr_last <= !cpu_instr_last;
      if (cpu_instr_last && cpu_addr_valid) pc_reg[7:0] <= pc_reg[7:0] + 8'h01;
      cnt_reg <= break_in_progress ? cnt_reg + 4'h1 : 4'h0;
      cpu_rti_exec <= break_in_progress && cnt_reg == rti_delay;
    end
  end
endmodule // abu_cpu_model
`default_nettype wire

// File: abu_defs.vh
`ifndef ABU_DEFS_VH
`define ABU_DEFS_VH
// Register byte offsets on the APB bus.
`define ABU_OFF_CTRL 12'h000
`define ABU_OFF_ADDRH 12'h004
`define ABU_OFF_ADDRL 12'h008
`define ABU_OFF_WAKE 12'h00C
`define ABU_OFF_FLAGCLR 12'h010
`define ABU_OFF_AUX 12'h014
// Field positions.
`define ABU_BIT_ENABLE 7
`define ABU_BIT_ACTIVE 6
`define ABU_BIT_WAIT 1
`define ABU_BIT_CLRFE 7
`define ABU_BIT_BDWD 0
// Reset values.
`define ABU_RST_BYTE 8'h00
// Break vectors.
`define ABU_VEC_USER 16'hFFFC
`define ABU_VEC_MON 16'hFEFC
`endif

// File: tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, monitor_mode = 0;
  logic waiting = 0, cpu_in_stop = 0, pready, pslverr, se, cpu_addr_valid, cpu_instr_last;
  logic cpu_rti_exec, cpu_in_wait, break_request, break_in_progress, wake_request;
  logic timer_freeze, watchdog_inhibit, status_clear_allow;
  logic [3:0] rti_delay = 4'hF;
  logic [11:0] paddr = 12'h000;
  logic [15:0] cpu_addr, break_vector;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  int err_count = 0, check_count = 0, i;
  abu_breakpoint i_dut (.*);
  abu_cpu_model i_cpu (.*);
  initial forever #12.5 pclk = ~pclk;
  initial begin
    #100us err_count++;
    results;
  end
  task chk(input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    {rd, se, psel, penable} <= {prdata, pslverr, 2'b00};
    @(posedge pclk);
  endtask
  task wbip(input logic v);
    for (i = 0; i < 600 && break_in_progress !== v; i++) @(negedge pclk);
    chk(break_in_progress, v);
    @(posedge pclk);
  endtask
  task t_reset;
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, 12'(4 * k), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 12'h018, 32'h0);
    chk(rd, 32'h0);
    chk(se, 1'b1);
    $display("t_reset done");
  endtask
  task t_match;
    apb(1'b1, 12'h004, 32'h12);
    apb(1'b1, 12'h008, 32'h34);
    apb(1'b1, 12'h000, 32'h80);
    wbip(1'b1);
    chk(break_vector, 32'hFFFC);
    chk({timer_freeze, watchdog_inhibit, status_clear_allow}, 3'b100);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'hC0);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    wbip(1'b0);
    $display("t_match done");
  endtask
  task t_soft;
    {rti_delay, monitor_mode, waiting} <= {4'h6, 2'b11};
    apb(1'b1, 12'h014, 32'h1);
    apb(1'b1, 12'h010, 32'h80);
    apb(1'b1, 12'h000, 32'h40);
    wbip(1'b1);
    chk(break_vector, 32'hFEFC);
    chk({watchdog_inhibit, status_clear_allow}, 2'b11);
    waiting <= 1'b0;
    wbip(1'b0);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, 12'h00C, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h0);
    $display("t_soft done");
  endtask
  task t_stop;
    cpu_in_stop <= 1'b1;
    apb(1'b1, 12'h000, 32'h40);
    wbip(1'b1);
    chk(timer_freeze, 1'b1);
    cpu_in_stop <= 1'b0;
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h2);
    wbip(1'b0);
    apb(1'b1, 12'h00C, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h0);
    $display("t_stop done");
  endtask
  task results;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_match;
    t_soft;
    t_stop;
    results;
  end
endmodule // tb
`default_nettype wire
